//--- hw/ee_mst.sv
// bus master for the eeprom link: makes scl, runs whole transactions
// assumes one command at a time; write data is handed over per byte
`timescale 1ns/100ps
`include "ee_defines.svh"
module ee_mst (
  ee_if.mst bus, // two-wire link, master side
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic cmd_valid, // start a command
  input ee_pkg::ee_op_t cmd_op, // command kind
  input wire logic [8:0] cmd_addr, // array address
  input wire logic [4:0] cmd_len, // byte count, 0 acts as 1
  input wire logic [7:0] wr_data, // next write byte
  output logic cmd_ready, // idle, command may start
  output logic wr_take, // wr_data taken this cycle
  output logic [7:0] rd_data, // last byte read
  output logic rd_valid, // rd_data new this cycle
  output logic done, // command finished
  output logic nack // last command was refused
);
  import ee_pkg::*;

  ee_mst_t r;
  ee_mst_t n;
  logic tick;
  logic sda_h;
  logic last;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  // each bit takes four quarter ticks: set data, raise, sample, lower
  always_comb begin
    n = r;
    n.sda_s = {r.sda_s[0], bus.sda};
    sda_h = r.sda_s[1];
    last = (r.len <= 5'h1);
    tick = (r.div == 3'(`EE_QTR_CYC - 1));
    n.rd_valid = 1'b0;
    n.wr_take = 1'b0;
    n.done = 1'b0;
    if (r.ph != M_IDLE) begin
      n.div = tick ? 3'h0 : r.div + 1'b1;
    end
    case (r.ph)
      M_IDLE: begin
        n.scl = 1'b1;
        n.sda_oe = 1'b0;
        if (cmd_valid) begin
          n.op = cmd_op;
          n.addr = cmd_addr;
          n.len = cmd_len;
          n.nack = 1'b0;
          n.ph = M_START;
          n.stg = (cmd_op == OP_READ_CUR) ? G_SLA_RD : G_SLA;
          n.q = '0;
          n.div = '0;
        end
      end
      M_START: if (tick) begin
        n.q = r.q + 1'b1;
        case (r.q)
          2'h0: n.sda_oe = 1'b0;
          2'h1: n.scl = 1'b1;
          2'h2: n.sda_oe = 1'b1;
          default: begin
            n.scl = 1'b0;
            n.ph = M_TX;
            n.b = '0;
            n.sh = {`EE_GROUP, `EE_PAD, r.addr[8], (r.stg == G_SLA_RD) ? `EE_RD : `EE_WR};
          end
        endcase
      end
      M_TX, M_RX: if (tick) begin
        n.q = r.q + 1'b1;
        case (r.q)
          2'h0: begin
            if (r.b == `EE_ACK_BIT) begin
              n.sda_oe = (r.ph == M_RX) && !last;
            end else begin
              n.sda_oe = (r.ph == M_TX) && !r.sh[`EE_MSB];
            end
          end
          2'h1: n.scl = 1'b1;
          2'h2: begin
            if (r.b == `EE_ACK_BIT) begin
              n.nack = (r.ph == M_TX) ? sda_h : r.nack;
            end else if (r.ph == M_RX) begin
              n.sh = {r.sh[`EE_MSB-1:0], sda_h};
            end
          end
          default: begin
            n.scl = 1'b0;
            n.b = r.b + 1'b1;
            if (r.ph == M_TX && r.b != `EE_ACK_BIT) begin
              n.sh = r.sh << 1;
            end
            if (r.b == `EE_ACK_BIT) begin
              // byte and acknowledge done: pick the next step
              n.b = '0;
              case (r.stg)
                G_SLA: begin
                  if (r.nack || r.op == OP_POLL) begin
                    n.ph = M_STOP;
                  end else begin
                    n.stg = G_WADDR;
                    n.sh = r.addr[7:0];
                  end
                end
                G_WADDR: begin
                  if (r.nack) begin
                    n.ph = M_STOP;
                  end else if (r.op == OP_READ_SEL) begin
                    n.ph = M_START;
                    n.stg = G_SLA_RD;
                  end else begin
                    n.stg = G_WDATA;
                    n.sh = wr_data;
                    n.wr_take = 1'b1;
                  end
                end
                G_WDATA: begin
                  if (r.nack || last) begin
                    n.ph = M_STOP;
                  end else begin
                    n.len = r.len - 1'b1;
                    n.sh = wr_data;
                    n.wr_take = 1'b1;
                  end
                end
                G_SLA_RD: begin
                  n.ph = r.nack ? M_STOP : M_RX;
                  n.stg = G_RDATA;
                end
                default: begin
                  n.rd_data = r.sh;
                  n.rd_valid = 1'b1;
                  n.len = r.len - 1'b1;
                  n.ph = last ? M_STOP : M_RX;
                end
              endcase
            end
          end
        endcase
      end
      M_STOP: if (tick) begin
        n.q = r.q + 1'b1;
        case (r.q)
          2'h0: n.sda_oe = 1'b1;
          2'h1: n.scl = 1'b1;
          2'h2: n.sda_oe = 1'b0;
          default: begin
            n.ph = M_IDLE;
            n.done = 1'b1;
          end
        endcase
      end
      default: n.ph = M_IDLE;
    endcase
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.ph <= M_IDLE;
      r.scl <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign bus.scl = r.scl;
  assign bus.m_sda_oe = r.sda_oe;
  assign bus.m_sda_o = 1'b0;
  assign cmd_ready = (r.ph == M_IDLE);
  assign wr_take = r.wr_take;
  assign rd_data = r.rd_data;
  assign rd_valid = r.rd_valid;
  assign done = r.done;
  assign nack = r.nack;
endmodule

//--- hw/ee_defines.svh
// constants shared by both ends of the serial eeprom link
// assumes a 20 MHz system clock on both ends
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH
// -------------------------------------------------------------
// clock and timing
// -------------------------------------------------------------
`define EE_CLK_MHZ 20
`define EE_TWR_US 5000
`define EE_TWR_CYC (`EE_TWR_US * `EE_CLK_MHZ)
`define EE_QTR_NS 250
`define EE_QTR_CYC ((`EE_QTR_NS * `EE_CLK_MHZ) / 1000)
// -------------------------------------------------------------
// frame layout
// -------------------------------------------------------------
`define EE_GROUP 4'ha
`define EE_GRP_F 7:4
`define EE_A8_POS 1
`define EE_RW_POS 0
`define EE_MSB 7
`define EE_ACK_BIT 4'h8
`define EE_PAGE_F 8:4
`define EE_OFF_F 3:0
`define EE_PAGE_BYTES 16
`define EE_MEM_BYTES 512
`define EE_ERASED 8'hff
`define EE_RD 1'b1
`define EE_WR 1'b0
`define EE_PAD 2'h0
`endif

//--- hw/ee_pkg.sv
// types shared by the eeprom slave and the bus master
// assumes ee_defines.svh is on the include path
`include "ee_defines.svh"
package ee_pkg;
  typedef logic [16:0] ee_tmr_t;
  typedef logic [3:0] ee_off_t;
  typedef logic [8:0] ee_addr_t;
  typedef enum {D_IDLE, D_SLA, D_WADDR, D_WDATA, D_RDATA} ee_dst_t;
  typedef enum {M_IDLE, M_START, M_TX, M_RX, M_STOP} ee_mph_t;
  typedef enum {G_SLA, G_WADDR, G_WDATA, G_SLA_RD, G_RDATA} ee_stg_t;
  typedef enum logic [1:0] {OP_WRITE, OP_READ_SEL, OP_READ_CUR, OP_POLL} ee_op_t;
  // slave state
  typedef struct packed {
    ee_dst_t st;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] wp_s;
    logic scl_p;
    logic sda_p;
    logic [3:0] cnt;
    logic ackph;
    logic mack;
    logic sda_oe;
    logic rw;
    logic a8;
    logic [7:0] sh;
    logic [7:0] tx;
    ee_addr_t addr;
    ee_off_t off;
    logic wp_lat;
    logic pend;
    logic [`EE_PAGE_BYTES-1:0] vld;
    logic [`EE_PAGE_BYTES-1:0][7:0] pbuf;
    ee_tmr_t tmr;
    logic busy;
    logic [`EE_MEM_BYTES-1:0][7:0] mem;
  } ee_dev_t;
  // master state
  typedef struct packed {
    ee_mph_t ph;
    ee_stg_t stg;
    ee_op_t op;
    logic [2:0] div;
    logic [1:0] q;
    logic [3:0] b;
    logic [7:0] sh;
    ee_addr_t addr;
    logic [4:0] len;
    logic scl;
    logic sda_oe;
    logic [1:0] sda_s;
    logic nack;
    logic [7:0] rd_data;
    logic rd_valid;
    logic wr_take;
    logic done;
  } ee_mst_t;
endpackage

//--- hw/ee_if.sv
// two-wire link between the bus master and the eeprom slave
// scl is pushed by the master only; sda is wired-and with a pull-up
`timescale 1ns/100ps
interface ee_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic sda;
  // resolved line level, released means pulled high
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);
  modport mst (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

//--- hw/ee_dev.sv
// eeprom slave: command engine, page buffer and 512-byte array
// assumes scl and sda come from another clock domain and the master keeps
// each scl phase well above four system clock cycles
`timescale 1ns/100ps
`include "ee_defines.svh"
module ee_dev #(
  parameter int unsigned WR_CYCLES = `EE_TWR_CYC // programming interval in clk cycles
) (
  ee_if.dev bus, // two-wire link, slave side
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic wp, // write protect pin
  output logic prog_busy // programming cycle running
);
  import ee_pkg::*;

  // r is the registered state, n its next value
  ee_dev_t r;
  ee_dev_t n;
  // edge and condition flags decoded from the synchronised pins
  logic scl_h;
  logic sda_h;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  // pins pass two flops; the third stage is only an edge reference
  always_comb begin
    n = r;
    n.scl_s = {r.scl_s[0], bus.scl};
    n.sda_s = {r.sda_s[0], bus.sda};
    n.wp_s = {r.wp_s[0], wp};
    n.scl_p = r.scl_s[1];
    n.sda_p = r.sda_s[1];
    scl_h = r.scl_s[1];
    sda_h = r.sda_s[1];
    rise = scl_h & ~r.scl_p;
    fall = ~scl_h & r.scl_p;
    start_c = scl_h & r.scl_p & r.sda_p & ~sda_h;
    stop_c = scl_h & r.scl_p & ~r.sda_p & sda_h;
    // programming interval counts down on its own
    // nothing else clears busy, so a stop can never shorten it
    if (r.busy) begin
      n.tmr = r.tmr - 1'b1;
      if (r.tmr == ee_tmr_t'(1)) begin
        n.busy = 1'b0;
      end
    end
    if (start_c) begin
      // a repeated start keeps the address, which makes selective read work
      // a start mid-byte drops that byte; a pending page still waits for stop
      n.st = D_SLA;
      n.cnt = '0;
      n.ackph = 1'b0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.st = D_IDLE;
      n.cnt = '0;
      n.ackph = 1'b0;
      n.sda_oe = 1'b0;
      // an address-only session leaves pend low and programs nothing
      if (r.pend) begin
        // only bytes actually received are written, the rest keep their value
        for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
          if (r.vld[i]) begin
            n.mem[{r.addr[`EE_PAGE_F], ee_off_t'(i)}] = r.pbuf[i];
          end
        end
        n.busy = 1'b1;
        n.tmr = ee_tmr_t'(WR_CYCLES);
        n.pend = 1'b0;
        n.vld = '0;
        n.addr = {r.addr[`EE_PAGE_F], r.off};
      end
    end else if (r.st != D_IDLE) begin
      // scl rise: data bits shift in, the ninth clock reads the master ack
      if (rise) begin
        if (r.ackph) begin
          n.mack = ~sda_h;
        end else begin
          n.sh = {r.sh[`EE_MSB-1:0], sda_h};
          n.cnt = r.cnt + 1'b1;
        end
      end
      // scl fall: ack decisions and outgoing bits change only here
      if (fall) begin
        if (r.ackph) begin
          // end of the ninth clock: release or start the next data byte
          n.ackph = 1'b0;
          n.cnt = '0;
          n.sda_oe = 1'b0;
          case (r.st)
            D_SLA: begin
              if (r.rw) begin
                n.st = D_RDATA;
                n.sda_oe = ~r.mem[r.addr][`EE_MSB];
                n.tx = r.mem[r.addr] << 1;
              end else begin
                n.st = D_WADDR;
              end
            end
            D_WADDR: begin
              n.st = D_WDATA;
              // strobe: the fall that ends the word address ack
              n.wp_lat = r.wp_s[1];
            end
            D_RDATA: begin
              // plain 9-bit overflow gives the wrap to zero
              n.addr = r.addr + 1'b1;
              if (r.mack) begin
                n.sda_oe = ~r.mem[n.addr][`EE_MSB];
                n.tx = r.mem[n.addr] << 1;
              end else begin
                n.st = D_IDLE;
              end
            end
            default: begin
              n.st = r.st;
            end
          endcase
        end else if (r.cnt == `EE_ACK_BIT) begin
          // eight bits in: decide the acknowledge
          n.ackph = 1'b1;
          n.sda_oe = 1'b0;
          case (r.st)
            D_SLA: begin
              if (r.sh[`EE_GRP_F] == `EE_GROUP && !r.busy) begin
                n.sda_oe = 1'b1;
                n.rw = r.sh[`EE_RW_POS];
                n.a8 = r.sh[`EE_A8_POS];
              end else begin
                // foreign group or busy: line stays released until the next start
                n.st = D_IDLE;
              end
            end
            D_WADDR: begin
              n.sda_oe = 1'b1;
              n.addr = {r.a8, r.sh};
              n.off = r.sh[`EE_OFF_F];
              n.vld = '0;
              n.pend = 1'b0;
            end
            D_WDATA: begin
              if (r.wp_lat) begin
                // protected: no ack and the whole request is dropped
                n.st = D_IDLE;
                n.pend = 1'b0;
                n.vld = '0;
              end else begin
                n.sda_oe = 1'b1;
                n.pbuf[r.off] = r.sh;
                n.vld[r.off] = 1'b1;
                n.off = r.off + 1'b1;
                n.pend = 1'b1;
              end
            end
            default: begin
              n.sda_oe = 1'b0;
            end
          endcase
        end else if (r.st == D_RDATA) begin
          n.sda_oe = ~r.tx[`EE_MSB];
          n.tx = r.tx << 1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  // array reset to erased is a model choice, a real part keeps its data
  // pin flops reset low; the rising pins seen after reset are ignored while idle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= D_IDLE;
      r.mem <= {`EE_MEM_BYTES{`EE_ERASED}};
    end else begin
      r <= n;
    end
  end

  // sda enable and busy come straight from the state register; sda data is tied low
  assign bus.d_sda_oe = r.sda_oe;
  assign bus.d_sda_o = 1'b0; // open drain, only ever pulls low
  assign prog_busy = r.busy;
endmodule

//--- dv/ee_asserts.sv
// checker for the two-wire link between bus master and eeprom slave
// assumes it sits beside the link interface, everything sampled on clk
`timescale 1ns/100ps
module ee_asserts #(
  parameter int unsigned WR_CYCLES = 100000 // programming interval, clk cycles
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic scl, // serial clock from master
  input wire logic sda, // resolved data line
  input wire logic d_sda_oe, // slave pulls sda low
  input wire logic prog_busy, // programming running
  input wire logic wp // write protect pin
);
  // ----
  // helper
  // ----
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  logic scl_q_r;
  logic sda_q_r;
  logic wp_sess_r;
  logic wp_sess_nxt;
  // a counter, not a repetition, so long intervals stay cheap
  always_comb begin
    busy_cnt_nxt = prog_busy ? busy_cnt_r + 32'h1 : 32'h0;
    // protected session: wp high from the start on, so also at the strobe
    wp_sess_nxt = wp_sess_r & wp;
    if (scl && scl_q_r && sda_q_r && !sda) begin
      wp_sess_nxt = wp;
    end
  end
  // register the count and the session flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_cnt_r <= 32'h0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      wp_sess_r <= 1'b0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
      scl_q_r <= scl;
      sda_q_r <= sda;
      wp_sess_r <= wp_sess_nxt;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_busy_silent: assert property (prog_busy |-> !d_sda_oe)
    else $error("slave drove sda while programming");
  a_busy_len: assert property ($fell(prog_busy) |-> busy_cnt_r == WR_CYCLES)
    else $error("programming interval has wrong length");
  a_prog_at_stop: assert property ($rose(prog_busy) |-> scl && sda && !$past(sda, 6))
    else $error("programming started without a stop");
  a_wp_no_prog: assert property ($rose(prog_busy) |-> !wp_sess_r)
    else $error("programming started in a protected session");
  a_slave_change_low: assert property ($changed(d_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("slave changed sda outside scl low");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*5])
    else $error("scl high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*5])
    else $error("scl low phase too short");
  a_start_hold: assert property ($fell(sda) && scl |-> scl [*4])
    else $error("start hold too short");
endmodule

//--- dv/tb_i2c_eeprom_rw_engine.sv
// self-checking bench: master and eeprom slave face each other on one link
// assumes design files and checker are compiled first
`timescale 1ns/100ps
module tb_i2c_eeprom_rw_engine;
  import ee_pkg::*;
  // ----
  // setup
  // ----
  localparam int WRC = 400; // short programming interval keeps the run brief
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wp = 1'b0;
  logic cmd_valid = 1'b0;
  ee_op_t cmd_op = OP_WRITE;
  logic [8:0] cmd_addr = 9'h000;
  logic [4:0] cmd_len = 5'h01;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, wr_take, rd_valid, done, nack, prog_busy;
  logic [7:0] rd_data;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  bit wp_late = 1'b0; // raise wp well after the strobe in the next write
  logic [31:0] seed = 32'h541f;
  logic [7:0] mem [512]; // model array
  logic [8:0] cur = 9'h000; // model address
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  ee_if bus_if ();
  ee_dev #(.WR_CYCLES(WRC)) ee_dev_inst (.bus(bus_if), .clk(clk), .sys_rst(sys_rst), .wp(wp),
    .prog_busy(prog_busy));
  ee_mst ee_mst_inst (.bus(bus_if), .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data), .cmd_ready(cmd_ready), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack(nack));
  ee_asserts #(.WR_CYCLES(WRC)) ee_asserts_inst (.clk(clk), .sys_rst(sys_rst), .scl(bus_if.scl),
    .sda(bus_if.sda), .d_sda_oe(bus_if.d_sda_oe), .prog_busy(prog_busy), .wp(wp));
  // clock
  always #25 clk = ~clk;
  // hang guard, about twice the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      finish_test();
    end
  end
  // ----
  // tasks
  // ----
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(string what, logic [8:0] exp, logic [8:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one command; the next write byte is put up a cycle after wr_take so either sampling edge is safe
  task automatic run(ee_op_t op, logic [8:0] a, int n);
    int t;
    bit tk;
    tk = 1'b0;
    do @(posedge clk) #1; while (cmd_ready !== 1'b1);
    cmd_op = op;
    cmd_addr = a;
    cmd_len = 5'(n);
    wr_data = wq.size() > 0 ? wq[0] : 8'h00;
    cmd_valid = 1'b1;
    for (t = 0; t < 6000; t++) begin
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      if (tk && wq.size() > 0) begin
        void'(wq.pop_front());
        wr_data = wq.size() > 0 ? wq[0] : 8'h00;
        // second data byte under way, long past the strobe
        if (wp_late && wq.size() + 2 == n) wp = 1'b1;
      end
      tk = (wr_take === 1'b1);
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (done === 1'b1) break;
    end
    check("done", 9'h001, {8'h00, done});
    if (done !== 1'b1) finish_test();
  endtask
  // write n random bytes at a; unless protected, update the model, poll once while busy, wait for busy to drop, poll again
  task automatic wr(logic [8:0] a, int n);
    logic [7:0] d [$];
    int i;
    bit prot;
    prot = wp;
    for (i = 0; i < n; i++) d.push_back(8'(rnd()));
    wq = d;
    run(OP_WRITE, a, n);
    check("wp nack", {8'h00, prot}, {8'h00, nack});
    check("busy", {8'h00, !prot}, {8'h00, prog_busy});
    if (prot == 1'b0) begin
      for (i = 0; i < n; i++) mem[{a[8:4], a[3:0] + 4'(i)}] = d[i];
      cur = {a[8:4], a[3:0] + 4'(n)};
      run(OP_POLL, a, 1);
      check("poll busy", 9'h001, {8'h00, nack});
      // look off the edge so the busy flag is settled
      for (i = 0; i < 2 * WRC && prog_busy === 1'b1; i++) begin
        @(posedge clk);
        #1;
      end
      run(OP_POLL, a, 1);
      check("poll ready", 9'h000, {8'h00, nack});
    end
  endtask
  // read n bytes, from a when sel is set, else from the current address
  task automatic rd(logic [8:0] a, int n, bit sel);
    logic [8:0] p;
    int i;
    p = sel ? a : cur;
    rq = {};
    run(sel ? OP_READ_SEL : OP_READ_CUR, a, n);
    check("rd count", 9'(n), 9'(rq.size()));
    for (i = 0; i < n && i < rq.size(); i++) begin
      check("rd byte", {1'b0, mem[p]}, {1'b0, rq[i]});
      p++;
    end
    cur = p;
  endtask
  task automatic endt(string s);
    $display("test %s finished, mismatches so far %0d", s, bad_count);
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    logic [8:0] a;
    for (int i = 0; i < 512; i++) mem[i] = 8'hff;
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    rd(9'h1f0, 3, 1);
    endt("erased array");
    wr(9'h105, 1);
    rd(9'h105, 1, 1);
    rd(9'h000, 2, 0);
    endt("byte write");
    wr(9'h13c, 18);
    rd(9'h000, 2, 0);
    rd(9'h130, 16, 1);
    endt("page wrap");
    wp = 1'b1;
    wr(9'h020, 2);
    wp = 1'b0;
    rd(9'h020, 2, 1);
    endt("write protect");
    wp_late = 1'b1;
    wr(9'h0a0, 3);
    wp_late = 1'b0;
    wp = 1'b0;
    rd(9'h0a0, 3, 1);
    endt("late protect");
    wr(9'h1ff, 1);
    rd(9'h1fe, 4, 1);
    endt("address wrap");
    repeat (3) begin
      a = 9'(rnd());
      wr(a, 1 + int'(rnd() % 17));
      rd(a & 9'h1f0, 16, 1);
    end
    endt("random pages");
    finish_test();
  end
endmodule
